// [shared/uart_fifo_pkg.sv]
package uart_fifo_pkg;
   // ----------------------------------------------------------------
   // Storage geometry
   // ----------------------------------------------------------------
   localparam int unsigned PTR_W = 4;
   localparam int unsigned CNT_W = 5;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam logic [4:0] FIFO_FULL = 5'h10;
   localparam logic [4:0] HOLD_ONE = 5'h01;
   localparam logic [4:0] TX_PAIR = 5'h02;
   localparam int unsigned RX_W = 11;
   localparam int unsigned RX_ERR_LSB = 8;
   localparam int unsigned RX_ERR_MSB = 10;

   // ----------------------------------------------------------------
   // Register indexes (byte address = index * 4)
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_IDX_LSB = 2;
   localparam int unsigned ADDR_IDX_MSB = 4;
   localparam logic [2:0] IDX_RX_BUF = 3'h0;
   localparam logic [2:0] IDX_INT_ENABLE = 3'h1;
   localparam logic [2:0] IDX_INT_IDENT = 3'h2;
   localparam logic [2:0] IDX_LINE_STATUS = 3'h5;
   localparam logic [2:0] IDX_MODEM_STATUS = 3'h6;

   // ----------------------------------------------------------------
   // Field positions and codes
   // ----------------------------------------------------------------
   localparam int unsigned FC_ENABLE = 0;
   localparam int unsigned FC_RX_CLR = 1;
   localparam int unsigned FC_TX_CLR = 2;
   localparam int unsigned FC_DMA_MODE = 3;
   localparam int unsigned FC_TRIG_LSB = 6;
   localparam int unsigned FC_TRIG_MSB = 7;
   localparam int unsigned IE_RX_DATA = 0;
   localparam int unsigned IE_TX_EMPTY = 1;
   localparam int unsigned IE_LINE = 2;
   localparam int unsigned IE_MODEM = 3;
   localparam logic [3:0] IE_RESET = 4'h0;
   localparam logic [1:0] TRIG_SEL_1 = 2'h0;
   localparam logic [1:0] TRIG_SEL_4 = 2'h1;
   localparam logic [1:0] TRIG_SEL_8 = 2'h2;
   localparam logic [4:0] TRIG_1 = 5'h01;
   localparam logic [4:0] TRIG_4 = 5'h04;
   localparam logic [4:0] TRIG_8 = 5'h08;
   localparam logic [4:0] TRIG_14 = 5'h0e;
   localparam logic [3:0] IIR_NONE = 4'h1;
   localparam logic [3:0] IIR_LINE = 4'h6;
   localparam logic [3:0] IIR_RX_DATA = 4'h4;
   localparam logic [3:0] IIR_TIMEOUT = 4'hc;
   localparam logic [3:0] IIR_TX_EMPTY = 4'h2;
   localparam logic [3:0] IIR_MODEM = 4'h0;

   // ----------------------------------------------------------------
   // Character timing: 16 receive-clock ticks per bit, 4 characters
   // ----------------------------------------------------------------
   localparam int unsigned BIT_TICK_SHIFT = 4;
   localparam int unsigned TIMEOUT_SHIFT = 6;
   localparam int unsigned TMO_W = 10;
   localparam int unsigned DLY_W = 8;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ_WAIT = 2'b10,
      BUS_READ_DATA = 2'b11
   } bus_state_t;
endpackage

// [hw/byte_fifo.sv]
`timescale 1ns/1ps
module byte_fifo #(
   parameter int unsigned W = 8
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_clear,
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic [W-1:0] i_data,
   output logic [W-1:0] o_data,
   output logic [uart_fifo_pkg::CNT_W-1:0] o_count
);
   logic [W-1:0] mem_ff [uart_fifo_pkg::FIFO_DEPTH];
   logic [uart_fifo_pkg::PTR_W-1:0] wr_ptr_ff;
   logic [uart_fifo_pkg::PTR_W-1:0] rd_ptr_ff;
   logic [uart_fifo_pkg::CNT_W-1:0] count_ff;

   wire do_push = i_push & (count_ff != uart_fifo_pkg::FIFO_FULL);
   wire do_pop = i_pop & (count_ff != '0);

   // Clear wins over a push or pop in the same cycle
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else if (i_clear) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (do_push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
         if (do_pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
         if (do_push && !do_pop) count_ff <= count_ff + 1'b1;
         else if (do_pop && !do_push) count_ff <= count_ff - 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (do_push && !i_clear) mem_ff[wr_ptr_ff] <= i_data;
   end

   assign o_data = mem_ff[rd_ptr_ff];
   assign o_count = count_ff;
endmodule // byte_fifo

// [hw/uart_fifo_interrupt_control.sv]
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module uart_fifo_interrupt_control (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic i_rclk_en,
   input wire logic [3:0] i_char_bits,
   input wire logic i_rx_push,
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_parity_err,
   input wire logic i_rx_frame_err,
   input wire logic i_rx_break,
   output logic [7:0] o_tx_data,
   output logic o_tx_valid,
   input wire logic i_tx_take,
   input wire logic i_tx_shift_empty,
   input wire logic [7:0] i_modem_status,
   input wire logic i_modem_delta,
   output logic o_modem_read,
   output logic o_irq_output,
   output logic o_rx_dma_request,
   output logic o_tx_dma_request
);
   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   uart_fifo_pkg::bus_state_t state_ff;
   uart_fifo_pkg::bus_state_t nxt_state;
   logic [2:0] idx_ff;
   logic map_ff;
   logic [31:0] hrdata_ff;
   logic [7:0] rd_value;

   wire bus_req = i_hsel & i_hready & i_htrans[1];
   wire addr_mapped = ~|i_haddr[31:uart_fifo_pkg::ADDR_IDX_MSB+1];
   wire [2:0] addr_idx = i_haddr[uart_fifo_pkg::ADDR_IDX_MSB:uart_fifo_pkg::ADDR_IDX_LSB];
   wire wr_now = (state_ff == uart_fifo_pkg::BUS_WRITE) & map_ff;
   wire rd_now = (state_ff == uart_fifo_pkg::BUS_READ_WAIT) & map_ff;
   wire [7:0] wdata = i_hwdata[7:0];
   wire wr_buf = wr_now & (idx_ff == uart_fifo_pkg::IDX_RX_BUF);
   wire wr_ier = wr_now & (idx_ff == uart_fifo_pkg::IDX_INT_ENABLE);
   wire fc_wr = wr_now & (idx_ff == uart_fifo_pkg::IDX_INT_IDENT);
   wire rd_buf = rd_now & (idx_ff == uart_fifo_pkg::IDX_RX_BUF);
   wire rd_iir = rd_now & (idx_ff == uart_fifo_pkg::IDX_INT_IDENT);
   wire rd_lsr = rd_now & (idx_ff == uart_fifo_pkg::IDX_LINE_STATUS);
   wire rd_msr = rd_now & (idx_ff == uart_fifo_pkg::IDX_MODEM_STATUS);

   // Reads take one wait cycle so a write just before is already visible
   assign nxt_state = bus_req ? (i_hwrite ? uart_fifo_pkg::BUS_WRITE
                                          : uart_fifo_pkg::BUS_READ_WAIT)
                              : uart_fifo_pkg::BUS_IDLE;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_ff <= uart_fifo_pkg::BUS_IDLE;
         idx_ff <= '0;
         map_ff <= 1'b0;
      end else begin
         case (state_ff)
            uart_fifo_pkg::BUS_READ_WAIT: begin
               state_ff <= uart_fifo_pkg::BUS_READ_DATA;
            end
            uart_fifo_pkg::BUS_IDLE, uart_fifo_pkg::BUS_WRITE,
            uart_fifo_pkg::BUS_READ_DATA: begin
               state_ff <= nxt_state;
               if (bus_req) begin
                  idx_ff <= addr_idx;
                  map_ff <= addr_mapped;
               end
            end
            default: begin
               state_ff <= uart_fifo_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) hrdata_ff <= '0;
      else if (state_ff == uart_fifo_pkg::BUS_READ_WAIT) hrdata_ff <= {24'h0, rd_value};
   end

   assign o_hrdata = hrdata_ff;
   assign o_hreadyout = (state_ff != uart_fifo_pkg::BUS_READ_WAIT);
   assign o_hresp = 1'b0;

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic fifo_en_ff;
   logic dma_mode_ff;
   logic [1:0] trig_ff;
   logic [3:0] ier_ff;

   wire en_chg = fc_wr & (wdata[uart_fifo_pkg::FC_ENABLE] != fifo_en_ff);
   wire fc_live = fc_wr & wdata[uart_fifo_pkg::FC_ENABLE];
   wire rx_clear = en_chg | (fc_live & wdata[uart_fifo_pkg::FC_RX_CLR]);
   wire tx_clear = en_chg | (fc_live & wdata[uart_fifo_pkg::FC_TX_CLR]);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fifo_en_ff <= 1'b0;
         dma_mode_ff <= 1'b0;
         trig_ff <= uart_fifo_pkg::TRIG_SEL_1;
         ier_ff <= uart_fifo_pkg::IE_RESET;
      end else begin
         if (fc_wr) fifo_en_ff <= wdata[uart_fifo_pkg::FC_ENABLE];
         if (fc_live) begin
            dma_mode_ff <= wdata[uart_fifo_pkg::FC_DMA_MODE];
            trig_ff <= wdata[uart_fifo_pkg::FC_TRIG_MSB:uart_fifo_pkg::FC_TRIG_LSB];
         end
         if (wr_ier) ier_ff <= wdata[uart_fifo_pkg::IE_MODEM:uart_fifo_pkg::IE_RX_DATA];
      end
   end

   wire [4:0] trig_level = (trig_ff == uart_fifo_pkg::TRIG_SEL_1) ? uart_fifo_pkg::TRIG_1 :
                           (trig_ff == uart_fifo_pkg::TRIG_SEL_4) ? uart_fifo_pkg::TRIG_4 :
                           (trig_ff == uart_fifo_pkg::TRIG_SEL_8) ? uart_fifo_pkg::TRIG_8 :
                           uart_fifo_pkg::TRIG_14;
   // Without FIFOs each direction holds a single character
   wire [4:0] cap = fifo_en_ff ? uart_fifo_pkg::FIFO_FULL : uart_fifo_pkg::HOLD_ONE;

   // ----------------------------------------------------------------
   // Receive path
   // ----------------------------------------------------------------
   logic [uart_fifo_pkg::RX_W-1:0] rx_head;
   logic [4:0] rx_count;
   logic [4:0] rx_err_cnt_ff;
   logic [3:0] lsr_err_ff;
   logic head_load_ff;

   wire [2:0] rx_err_in = {i_rx_break, i_rx_frame_err, i_rx_parity_err};
   wire [2:0] head_err = rx_head[uart_fifo_pkg::RX_ERR_MSB:uart_fifo_pkg::RX_ERR_LSB];
   wire rx_full = (rx_count >= cap);
   wire rx_push_ok = i_rx_push & ~rx_full & ~rx_clear;
   wire overrun = i_rx_push & rx_full;
   wire rx_pop = rd_buf & (rx_count != '0);
   wire rx_empty = (rx_count == '0);

   byte_fifo #(.W(uart_fifo_pkg::RX_W)) u_rx_fifo (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_clear(rx_clear),
      .i_push(rx_push_ok),
      .i_pop(rx_pop),
      .i_data({rx_err_in, i_rx_data}),
      .o_data(rx_head),
      .o_count(rx_count)
   );

   // Errors of a character show once it is at the head of the queue
   wire [3:0] err_set = {head_load_ff & ~rx_empty ? head_err : 3'h0, overrun};
   wire [4:0] err_inc = {4'h0, rx_push_ok & (|rx_err_in)};
   wire [4:0] err_dec = {4'h0, rx_pop & (|head_err)};

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         head_load_ff <= 1'b0;
         lsr_err_ff <= '0;
         rx_err_cnt_ff <= '0;
      end else begin
         head_load_ff <= rx_pop | (rx_push_ok & rx_empty);
         lsr_err_ff <= (lsr_err_ff & ~{4{rd_lsr}}) | err_set;
         if (rx_clear) rx_err_cnt_ff <= '0;
         else rx_err_cnt_ff <= rx_err_cnt_ff + err_inc - err_dec;
      end
   end

   // ----------------------------------------------------------------
   // Character time-out
   // ----------------------------------------------------------------
   logic [uart_fifo_pkg::TMO_W-1:0] tmo_cnt_ff;
   logic tmo_flag_ff;

   // Four characters of i_char_bits bits, 16 receive ticks per bit
   wire [uart_fifo_pkg::TMO_W-1:0] tmo_limit =
      uart_fifo_pkg::TMO_W'(i_char_bits) << uart_fifo_pkg::TIMEOUT_SHIFT;
   wire tmo_restart = rx_push_ok | rx_pop | rx_clear | rx_empty;
   wire tmo_set = fifo_en_ff & ~tmo_restart & (tmo_cnt_ff == tmo_limit);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tmo_cnt_ff <= '0;
         tmo_flag_ff <= 1'b0;
      end else begin
         if (tmo_restart) tmo_cnt_ff <= '0;
         else if (i_rclk_en && tmo_cnt_ff != tmo_limit) tmo_cnt_ff <= tmo_cnt_ff + 1'b1;
         tmo_flag_ff <= (tmo_flag_ff & ~(rx_pop | rx_clear)) | tmo_set;
      end
   end

   // ----------------------------------------------------------------
   // Transmit path and empty interrupt timing
   // ----------------------------------------------------------------
   logic [4:0] tx_count;
   logic two_seen_ff;
   logic immediate_ff;
   logic dly_busy_ff;
   logic [uart_fifo_pkg::DLY_W-1:0] dly_cnt_ff;
   logic holding_empty_flag_pend_ff;
   logic [3:0] iir_code;

   wire tx_push = wr_buf & (tx_count < cap);
   wire tx_pop = i_tx_take & (tx_count != '0);
   wire tx_empty = (tx_count == '0);
   wire empty_evt = tx_clear | (tx_pop & (tx_count == uart_fifo_pkg::HOLD_ONE) & ~tx_push);
   // One character minus its final stop bit
   wire [uart_fifo_pkg::DLY_W-1:0] dly_limit =
      uart_fifo_pkg::DLY_W'(i_char_bits - 4'h1) << uart_fifo_pkg::BIT_TICK_SHIFT;
   wire fast_empty = two_seen_ff | immediate_ff | en_chg | ~fifo_en_ff;
   wire dly_done = dly_busy_ff & (dly_cnt_ff == dly_limit) & ~tx_push;
   wire ier_rise = wr_ier & wdata[uart_fifo_pkg::IE_TX_EMPTY] & ~ier_ff[uart_fifo_pkg::IE_TX_EMPTY];
   wire holding_empty_flag_set = (empty_evt & fast_empty) | dly_done | (ier_rise & tx_empty & ~tx_push);
   wire iir_clr = rd_iir & (iir_code == uart_fifo_pkg::IIR_TX_EMPTY);

   byte_fifo #(.W(8)) u_tx_fifo (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_clear(tx_clear),
      .i_push(tx_push),
      .i_pop(tx_pop),
      .i_data(wdata),
      .o_data(o_tx_data),
      .o_count(tx_count)
   );

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         two_seen_ff <= 1'b0;
         immediate_ff <= 1'b1;
         dly_busy_ff <= 1'b0;
         dly_cnt_ff <= '0;
      end else begin
         if (empty_evt) two_seen_ff <= 1'b0;
         else if (tx_count >= uart_fifo_pkg::TX_PAIR) two_seen_ff <= 1'b1;
         if (en_chg) immediate_ff <= 1'b1;
         else if (holding_empty_flag_set) immediate_ff <= 1'b0;
         if (empty_evt && !fast_empty) begin
            dly_busy_ff <= 1'b1;
            dly_cnt_ff <= '0;
         end else if (tx_push || dly_done) begin
            dly_busy_ff <= 1'b0;
         end else if (dly_busy_ff && i_rclk_en) begin
            dly_cnt_ff <= dly_cnt_ff + 1'b1;
         end
      end
   end

   // Set wins over a clear landing in the same cycle
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) holding_empty_flag_pend_ff <= 1'b0;
      else holding_empty_flag_pend_ff <= (holding_empty_flag_pend_ff & ~(wr_buf | iir_clr)) | holding_empty_flag_set;
   end

   // ----------------------------------------------------------------
   // Interrupt identification and outputs
   // ----------------------------------------------------------------
   logic irq_ff;
   logic rx_dma_ff;
   logic tx_dma_ff;
   logic modem_read_ff;

   wire ls_irq = ier_ff[uart_fifo_pkg::IE_LINE] & (|lsr_err_ff);
   wire rx_trig = fifo_en_ff ? (rx_count >= trig_level) : ~rx_empty;
   wire rda_irq = ier_ff[uart_fifo_pkg::IE_RX_DATA] & rx_trig;
   wire tmo_irq = ier_ff[uart_fifo_pkg::IE_RX_DATA] & fifo_en_ff & tmo_flag_ff;
   wire holding_empty_flag_irq = ier_ff[uart_fifo_pkg::IE_TX_EMPTY] & holding_empty_flag_pend_ff;
   wire mdm_irq = ier_ff[uart_fifo_pkg::IE_MODEM] & i_modem_delta;

   assign iir_code = ls_irq ? uart_fifo_pkg::IIR_LINE :
                     rda_irq ? uart_fifo_pkg::IIR_RX_DATA :
                     tmo_irq ? uart_fifo_pkg::IIR_TIMEOUT :
                     holding_empty_flag_irq ? uart_fifo_pkg::IIR_TX_EMPTY :
                     mdm_irq ? uart_fifo_pkg::IIR_MODEM :
                     uart_fifo_pkg::IIR_NONE;

   wire hold_empty = tx_empty;
   wire tx_idle = tx_empty & i_tx_shift_empty;
   wire fifo_err = fifo_en_ff & (rx_err_cnt_ff != '0);
   wire [7:0] lsr_value = {fifo_err, tx_idle, hold_empty, lsr_err_ff, ~rx_empty};
   wire [7:0] iir_value = {{2{fifo_en_ff}}, 2'b00, iir_code};

   assign rd_value = ~map_ff ? 8'h00 :
                     (idx_ff == uart_fifo_pkg::IDX_RX_BUF) ? rx_head[7:0] :
                     (idx_ff == uart_fifo_pkg::IDX_INT_ENABLE) ? {4'h0, ier_ff} :
                     (idx_ff == uart_fifo_pkg::IDX_INT_IDENT) ? iir_value :
                     (idx_ff == uart_fifo_pkg::IDX_LINE_STATUS) ? lsr_value :
                     (idx_ff == uart_fifo_pkg::IDX_MODEM_STATUS) ? i_modem_status :
                     8'h00;

   // Mode 1 signals in blocks; mode 0 per character
   wire mode1 = fifo_en_ff & dma_mode_ff;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_ff <= 1'b0;
         rx_dma_ff <= 1'b0;
         tx_dma_ff <= 1'b0;
         modem_read_ff <= 1'b0;
      end else begin
         irq_ff <= (iir_code != uart_fifo_pkg::IIR_NONE);
         rx_dma_ff <= mode1 ? ((rx_count >= trig_level) | tmo_flag_ff) : ~rx_empty;
         tx_dma_ff <= mode1 ? (tx_count < cap) : tx_empty;
         modem_read_ff <= rd_msr;
      end
   end

   assign o_irq_output = irq_ff;
   assign o_rx_dma_request = rx_dma_ff;
   assign o_tx_dma_request = tx_dma_ff;
   assign o_modem_read = modem_read_ff;
   assign o_tx_valid = ~tx_empty;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_empty_slow;
      empty_evt && !fast_empty && !ier_rise && !holding_empty_flag_pend_ff && !holding_empty_flag_set;
   endsequence

   sequence s_quiet_tick;
      !tx_push && !holding_empty_flag_set;
   endsequence

   ident_read_a: assert property (rd_iir |=> o_hrdata[3:0] == $past(iir_code))
      else $error("ident read returned wrong code");
   enable_flush_a: assert property (en_chg |=> rx_count == '0 && tx_count == '0)
      else $error("enable change left data in fifos");
   rx_clear_a: assert property (fc_live && wdata[uart_fifo_pkg::FC_RX_CLR] |=> rx_count == '0)
      else $error("receive clear ignored");
   tx_clear_a: assert property (fc_live && wdata[uart_fifo_pkg::FC_TX_CLR] |=> tx_count == '0)
      else $error("transmit clear ignored");
   tx_dma_mode_a: assert property (mode1 && tx_count < cap |=> o_tx_dma_request)
      else $error("mode 1 transmit request missing");
   rx_data_irq_a: assert property (rda_irq && fifo_en_ff |=> o_irq_output)
      else $error("trigger level reached without interrupt");
   line_clear_a: assert property (rd_lsr && !i_rx_push && !head_load_ff |=> lsr_err_ff == '0)
      else $error("line status read did not clear errors");
   data_ready_a: assert property (rx_push_ok |=> !rx_empty)
      else $error("stored character not flagged ready");
   tmo_needs_char_a: assert property (tmo_flag_ff |-> !rx_empty)
      else $error("time-out with empty receive fifo");
   tmo_tick_a: assert property (!i_rclk_en && !tmo_restart |=> $stable(tmo_cnt_ff))
      else $error("time-out counted without receive clock");
   tmo_clear_a: assert property (tmo_flag_ff && rx_pop |=> !tmo_flag_ff && tmo_cnt_ff == '0)
      else $error("buffer read did not clear time-out");
   holding_empty_flag_delay_a: assert property (s_empty_slow ##1 s_quiet_tick |=> !holding_empty_flag_pend_ff)
      else $error("empty interrupt was not delayed");
   ier_upper_a: assert property (rd_now && idx_ff == uart_fifo_pkg::IDX_INT_ENABLE
                                 |=> o_hrdata[7:4] == 4'h0)
      else $error("enable upper bits not zero");
   iir_top_a: assert property (rd_iir && fifo_en_ff |=> o_hrdata[7:6] == 2'b11
                               && o_hrdata[5:4] == 2'b00)
      else $error("ident fifo bits wrong");
endmodule // uart_fifo_interrupt_control

// [tb/serial_peer.sv]
`timescale 1ns/1ps
module serial_peer (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_send,
   input wire logic [7:0] i_byte,
   input wire logic i_take_on,
   input wire logic i_tx_valid,
   output logic o_rclk_en,
   output logic o_rx_push,
   output logic [7:0] o_rx_data,
   output logic o_tx_take
);
   // Receive clock at half rate keeps time-out waits short
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rclk_en <= 1'h0;
         o_rx_push <= 1'h0;
         o_rx_data <= 8'h00;
         o_tx_take <= 1'h0;
      end else begin
         o_rclk_en <= !o_rclk_en;
         o_rx_push <= i_send;
         o_rx_data <= i_send ? i_byte : ~o_rx_data; // Junk between characters
         o_tx_take <= i_take_on && i_tx_valid && !o_tx_take;
      end
   end
endmodule // serial_peer

// [tb/tb_uart_fifo_interrupt_control.sv]
`timescale 1ns/1ps
module tb_uart_fifo_interrupt_control;
   logic i_clk = 1'h0, i_reset_n = 1'h0, hwrite = 1'h0, rd_ph = 1'h0, send = 1'h0;
   logic take_on = 1'h0, delta = 1'h0, hrdy, rclk_en, push, txv, take;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [7:0] rx_byte = 8'h1d, rxd;
   logic perr = 1'h0, hresp, irq, rdma, tdma, mrd;
   logic [7:0] txd, mreads = 8'h00;
   logic [15:0] e;
   logic [15:0] expq[$];
   logic [7:0] rxq[$];
   int n_mismatch = 0, checks_done = 0;
   int lv[4] = '{1, 4, 8, 14};
   always #12.5 i_clk = ~i_clk;
   uart_fifo_interrupt_control i_uart_fifo_interrupt_control (.i_clk(i_clk),
      .i_reset_n(i_reset_n), .i_hsel(1'h1), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
      .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_rclk_en(rclk_en),
      .i_char_bits(4'ha), .i_rx_push(push), .i_rx_data(rxd), .i_rx_parity_err(perr),
      .i_rx_frame_err(1'h0), .i_rx_break(1'h0), .o_tx_data(txd), .o_tx_valid(txv),
      .i_tx_take(take), .i_tx_shift_empty(!take), .i_modem_status(rx_byte),
      .i_modem_delta(delta), .o_modem_read(mrd), .o_irq_output(irq),
      .o_rx_dma_request(rdma), .o_tx_dma_request(tdma));
   serial_peer i_serial_peer (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_send(send),
      .i_byte(rx_byte), .i_take_on(take_on), .i_tx_valid(txv), .o_rclk_en(rclk_en),
      .o_rx_push(push), .o_rx_data(rxd), .o_tx_take(take));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Read data phase ends where hready is high again
   always @(posedge i_clk) if (rd_ph && hrdy) begin
      e = expq.pop_front();
      chk("reg_read", hrdata[7:0] & e[15:8], e[7:0]);
      chk("hresp", {7'h0, hresp}, 8'h00);
   end
   always @(posedge i_clk) if (mrd) mreads <= mreads + 8'h01;
   task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d,
                      input logic [7:0] m);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {27'h0, idx, 2'h0};
      do @(posedge i_clk); while (hrdy !== 1'h1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      rd_ph <= !w;
      if (!w) expq.push_back({m, d & m});
      do @(posedge i_clk); while (hrdy !== 1'h1);
      rd_ph <= 1'h0;
   endtask
   task automatic rx(input int n);
      repeat (n) begin
         rxq.push_back(lfsr(rx_byte));
         rx_byte <= lfsr(rx_byte);
         send <= 1'h1;
         @(posedge i_clk);
         send <= 1'h0;
         @(posedge i_clk);
      end
   endtask
   initial begin
      repeat (12) @(posedge i_clk);
      i_reset_n <= 1'h1;
      @(posedge i_clk);
      bus(1'h0, 3'h2, 8'h01, 8'hff);
      bus(1'h1, 3'h1, 8'hff, 8'h00);
      bus(1'h0, 3'h1, 8'h0f, 8'hff);
      bus(1'h1, 3'h2, 8'h01, 8'h00);
      bus(1'h0, 3'h2, 8'hc2, 8'hff);
      bus(1'h0, 3'h2, 8'hc1, 8'hff);
      for (int t = 0; t < 4; t++) begin
         rxq.delete();
         bus(1'h1, 3'h2, {t[1:0], 6'h0b}, 8'h00);
         rx(lv[t] - 1);
         bus(1'h0, 3'h2, 8'hc1, 8'hff);
         rx(1);
         bus(1'h0, 3'h2, 8'hc4, 8'hff);
      end
      bus(1'h0, 3'h5, 8'h61, 8'he1);
      bus(1'h0, 3'h0, rxq.pop_front(), 8'hff);
      bus(1'h0, 3'h2, 8'hc1, 8'hff);
      chk("rx_dma", {7'h0, rdma}, 8'h00);
      repeat (1400) @(posedge i_clk);
      bus(1'h0, 3'h2, 8'hcc, 8'hff);
      chk("irq", {7'h0, irq}, 8'h01);
      chk("rx_dma", {7'h0, rdma}, 8'h01);
      bus(1'h0, 3'h0, rxq.pop_front(), 8'hff);
      bus(1'h0, 3'h2, 8'hc1, 8'hff);
      perr <= 1'h1;
      rx(5);
      perr <= 1'h0;
      bus(1'h0, 3'h2, 8'hc6, 8'hff);
      bus(1'h0, 3'h5, 8'h82, 8'h82);
      bus(1'h0, 3'h2, 8'hc4, 8'hff);
      bus(1'h1, 3'h0, 8'ha5, 8'h00);
      bus(1'h1, 3'h0, 8'h5a, 8'h00);
      bus(1'h1, 3'h1, 8'h02, 8'h00);
      bus(1'h0, 3'h2, 8'hc1, 8'hff);
      chk("tx_data", txd, 8'ha5);
      chk("tx_dma", {7'h0, tdma}, 8'h01);
      take_on <= 1'h1;
      repeat (20) @(posedge i_clk);
      bus(1'h0, 3'h2, 8'hc2, 8'hff);
      bus(1'h0, 3'h5, 8'h60, 8'h60);
      // Single byte: empty interrupt must wait about one character
      bus(1'h1, 3'h0, 8'h3c, 8'h00);
      repeat (8) @(posedge i_clk);
      bus(1'h0, 3'h2, 8'hc1, 8'hff);
      repeat (320) @(posedge i_clk);
      bus(1'h0, 3'h2, 8'hc2, 8'hff);
      bus(1'h1, 3'h1, 8'h08, 8'h00);
      delta <= 1'h1;
      bus(1'h0, 3'h2, 8'hc0, 8'hff);
      bus(1'h0, 3'h6, rx_byte, 8'hff);
      delta <= 1'h0;
      bus(1'h1, 3'h1, 8'h00, 8'h00);
      bus(1'h0, 3'h2, 8'hc1, 8'hff);
      bus(1'h1, 3'h2, 8'h00, 8'h00);
      bus(1'h0, 3'h2, 8'h01, 8'hff);
      chk("irq", {7'h0, irq}, 8'h00);
      bus(1'h0, 3'h5, 8'h00, 8'h01);
      bus(1'h0, 3'h3, 8'h00, 8'hff);
      chk("modem_read", mreads, 8'h01);
      summarize();
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      n_mismatch++;
      summarize();
   end
endmodule // tb_uart_fifo_interrupt_control
